// [core/ch2_pin_pkg.sv]
// constants and types shared by the channel-2 bit-5 pin multiplexer
`default_nettype none
package ch2_pin_pkg;
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int BYTE_CLK_PERIOD_NS = 80;
  localparam int BYTE_CLK_HALF_CYCLES = BYTE_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BYTE_CLK_HALF_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 1;
  localparam logic MODE_PACKET = 1'h0;
  localparam logic MODE_CLEAR_CHANNEL = 1'h1;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    ROLE_ADD_BUS = 3'h1,
    ROLE_PACKET = 3'h2,
    ROLE_FRAME = 3'h4
  } role_e;
endpackage
`default_nettype wire

// [core/bit_stream_if.sv]
// valid/ready stream carrier between the multiplexer and its fifo
`default_nettype none
interface bit_stream_if #(parameter int WIDTH = 1);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [core/bit_stream_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`default_nettype none
module bit_stream_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,   // system clock
  input wire logic rst_b_i, // synchronised reset, active low
  bit_stream_if.snk in_s,   // filling side
  bit_stream_if.src out_s   // draining side
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  assign in_s.ready = (count_reg != CNT_FULL);
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem_reg[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // bit_stream_fifo
`default_nettype wire

// [core/ch2_tx_bit5_pin_mux.sv]
// channel-2 transmit bit-5 pin: add bus bit, packet byte bit or frame pulse
`default_nettype none
module ch2_tx_bit5_pin_mux
  import ch2_pin_pkg::*;
(
  input wire logic clk_sys_i,                   // system clock, 100 MHz
  input wire logic rst_b_i,                     // async reset, active low
  input wire logic ch2_add_bus_clock_i,         // add bus clock from far side
  input wire logic add_bus_enable_i,            // add bus interface enabled
  input wire logic op_mode_i,                   // 0 packet, 1 clear-channel
  input wire logic frame_boundary_i,            // framer frame-boundary tick
  input wire logic pin_i,                       // pad input level
  output logic pin_o,                           // pad output level
  output logic pin_oe_o,                        // pad output enable
  output logic ch2_tx_packet_byte_clock_o,      // byte clock toward far side
  output logic bit_valid_o,                     // sampled bit valid
  output logic bit_o,                           // sampled bit
  input wire logic bit_ready_i,                 // consumer accepts bit
  output ch2_pin_pkg::role_e role_o,            // current pin role
  output logic overflow_o                       // add bus bit lost, pulse
);
  import ch2_pin_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] link_rst_reg;
  logic link_rst_n;
  logic slot_reg [2];
  logic wr_idx_reg;
  logic idx_meta_reg;
  logic idx_sync_reg;
  logic rd_idx_reg;
  logic add_bit_new;
  logic [1:0] pin_sync_reg;
  role_e role_reg;
  role_e role_next;
  logic [DIV_W-1:0] div_cnt_reg;
  logic byte_clk_reg;
  logic byte_rise;
  logic pin_out_reg;
  logic pin_oe_reg;
  logic out_valid_reg;
  logic out_data_reg;
  logic overflow_reg;
  logic out_take;

  bit_stream_if #(.WIDTH(FIFO_WIDTH)) fill_s ();
  bit_stream_if #(.WIDTH(FIFO_WIDTH)) drain_s ();

  function automatic role_e role_pick(input logic bus_en, input logic mode);
    if (bus_en) begin
      return ROLE_ADD_BUS;
    end else if (mode == MODE_CLEAR_CHANNEL) begin
      return ROLE_FRAME;
    end
    return ROLE_PACKET;
  endfunction

  // system reset release
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // link reset release, on the sampling edge of the link clock
  always_ff @(negedge ch2_add_bus_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_rst_reg <= SYNC_RESET;
    end else begin
      link_rst_reg <= {link_rst_reg[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_reg[1];

  // add bus capture, ping-pong slots keep each bit stable for two link cycles
  always_ff @(negedge ch2_add_bus_clock_i) begin
    slot_reg[wr_idx_reg] <= pin_i;
  end

  always_ff @(negedge ch2_add_bus_clock_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_idx_reg <= 1'b0;
    end else begin
      wr_idx_reg <= ~wr_idx_reg;
    end
  end

  // slot index crosses as a level through two flops
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      idx_meta_reg <= 1'b0;
      idx_sync_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
    end else begin
      idx_meta_reg <= wr_idx_reg;
      idx_sync_reg <= idx_meta_reg;
      if (add_bit_new) begin
        rd_idx_reg <= ~rd_idx_reg;
      end
    end
  end
  assign add_bit_new = (idx_sync_reg != rd_idx_reg);

  // pad input synchroniser for the packet role
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_reg <= SYNC_RESET;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], pin_i};
    end
  end

  always_comb begin
    role_next = role_pick(add_bus_enable_i, op_mode_i);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      role_reg <= ROLE_PACKET;
    end else begin
      role_reg <= role_next;
    end
  end

  // byte clock divider; held low while the fifo cannot take a bit
  assign byte_rise = (role_reg == ROLE_PACKET) && (div_cnt_reg == DIV_LAST)
                     && !byte_clk_reg && fill_s.ready;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= DIV_ZERO;
      byte_clk_reg <= 1'b0;
    end else begin
      case (role_reg)
        ROLE_PACKET: begin
          if (div_cnt_reg != DIV_LAST) begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
          end else if (byte_clk_reg || fill_s.ready) begin
            div_cnt_reg <= DIV_ZERO;
            byte_clk_reg <= ~byte_clk_reg;
          end
        end
        default: begin
          div_cnt_reg <= DIV_ZERO;
          byte_clk_reg <= 1'b0;
        end
      endcase
    end
  end

  // fifo filling: add bus bit or packet bit taken at the byte clock rise
  always_comb begin
    fill_s.valid = 1'b0;
    fill_s.data = '0;
    case (role_reg)
      ROLE_ADD_BUS: begin
        fill_s.valid = add_bit_new;
        fill_s.data = slot_reg[rd_idx_reg];
      end
      ROLE_PACKET: begin
        fill_s.valid = byte_rise;
        fill_s.data = pin_sync_reg[1];
      end
      default: begin
        fill_s.valid = 1'b0;
        fill_s.data = '0;
      end
    endcase
  end

  bit_stream_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_sys_i),
    .rst_b_i(rst_n),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // output stage so that the stream ports come from flops
  assign out_take = !out_valid_reg || bit_ready_i;
  assign drain_s.ready = out_take;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 1'b0;
    end else if (out_take) begin
      out_valid_reg <= drain_s.valid;
      out_data_reg <= drain_s.data[0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      overflow_reg <= 1'b0;
    end else begin
      overflow_reg <= (role_reg == ROLE_ADD_BUS) && add_bit_new && !fill_s.ready;
    end
  end

  // frame boundary pulse drive
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_oe_reg <= (role_next == ROLE_FRAME);
      pin_out_reg <= (role_next == ROLE_FRAME) && frame_boundary_i;
    end
  end

  assign pin_o = pin_out_reg;
  assign pin_oe_o = pin_oe_reg;
  assign ch2_tx_packet_byte_clock_o = byte_clk_reg;
  assign bit_valid_o = out_valid_reg;
  assign bit_o = out_data_reg;
  assign role_o = role_reg;
  assign overflow_o = overflow_reg;
endmodule // ch2_tx_bit5_pin_mux
`default_nettype wire

// [verification/pin_mux_chk.sv]
// port assertions for the channel-2 bit-5 pin multiplexer
`default_nettype none
module pin_mux_chk
  import ch2_pin_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic add_bus_enable_i, // add bus role
  input wire logic op_mode_i, // mode
  input wire logic frame_boundary_i, // frame tick
  input wire logic pin_o, // pad out
  input wire logic pin_oe_o, // pad enable
  input wire logic ch2_tx_packet_byte_clock_o, // byte clock
  input wire logic bit_valid_o, // valid
  input wire logic bit_o, // bit
  input wire logic bit_ready_i, // ready
  input var ch2_pin_pkg::role_e role_o, // role
  input wire logic overflow_o // drop pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up_reg;
  logic live;
  assign live = up_reg == 2'h3;
  // role follows inputs only once the internal reset is gone
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_ROLE_ADD: assert property (live && add_bus_enable_i |=> role_o == ROLE_ADD_BUS)
    else $error("role is not add bus");
  AST_ROLE_PKT: assert property (live && !add_bus_enable_i && !op_mode_i |=> role_o == ROLE_PACKET)
    else $error("role is not packet");
  AST_ROLE_FRM: assert property (live && !add_bus_enable_i && op_mode_i |=> role_o == ROLE_FRAME)
    else $error("role is not frame");
  AST_PULSE: assert property (live && !add_bus_enable_i && op_mode_i && $stable(op_mode_i)
    && $stable(add_bus_enable_i) && frame_boundary_i |=> pin_o) else $error("no frame pulse");
  AST_PULSE_ONE: assert property (pin_o |-> $past(frame_boundary_i))
    else $error("pin high without frame tick");
  AST_OE: assert property (pin_oe_o == (role_o == ROLE_FRAME))
    else $error("pad enable does not match role");
  AST_BCLK_HIGH: assert property (disable iff (!rst_b_i || add_bus_enable_i || op_mode_i)
    $rose(ch2_tx_packet_byte_clock_o) |-> ch2_tx_packet_byte_clock_o [*4] ##1
    !ch2_tx_packet_byte_clock_o) else $error("byte clock high phase wrong");
  AST_BCLK_IDLE: assert property ((role_o != ROLE_PACKET) [*2] |-> !ch2_tx_packet_byte_clock_o)
    else $error("byte clock outside packet role");
  AST_PKT_TAKE: assert property (disable iff (!rst_b_i || add_bus_enable_i || op_mode_i)
    $rose(ch2_tx_packet_byte_clock_o) && !bit_valid_o |-> ##[1:2] bit_valid_o)
    else $error("packet bit not delivered");
  AST_HOLD: assert property (bit_valid_o && !bit_ready_i |=> bit_valid_o && $stable(bit_o))
    else $error("stream bit not held");
  COV_PULSE: cover property (pin_o);
  COV_BCLK: cover property ($rose(ch2_tx_packet_byte_clock_o));
  COV_DROP: cover property (overflow_o);
endmodule // pin_mux_chk
bind ch2_tx_bit5_pin_mux pin_mux_chk i_pin_mux_chk (.clk_sys_i, .rst_b_i, .add_bus_enable_i,
  .op_mode_i, .frame_boundary_i, .pin_o, .pin_oe_o, .ch2_tx_packet_byte_clock_o, .bit_valid_o,
  .bit_o, .bit_ready_i, .role_o, .overflow_o);
`default_nettype wire

// [verification/far_end_model.sv]
// terminal equipment model: add bus clock and data toward the shared pin
`default_nettype none
module far_end_model (
  input wire logic run_i, // let the add bus clock run
  input wire logic byte_clk_i, // byte clock from the device
  output logic link_clk_o, // add bus clock, 32 ns
  output logic data_o // data toward the pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pat = 8'hB4;
  // clock stops low between bursts
  initial begin
    link_clk_o = 1'h1;
    data_o = 1'h0;
    #5 link_clk_o = 1'h0;
    forever begin
      #16;
      if (run_i || link_clk_o) link_clk_o = ~link_clk_o;
    end
  end
  // data moves after rising edges, steady at every sampling edge
  always @(posedge link_clk_o or posedge byte_clk_i) begin
    pat <= {pat[6:0], pat[7]};
    data_o <= pat[7];
  end
endmodule // far_end_model
`default_nettype wire

// [verification/tb_top.sv]
// testbench for the channel-2 bit-5 pin multiplexer
`default_nettype none
module tb_top;
  import ch2_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic en = 1'h0, op = 1'h1, fb = 1'h0, rdy = 1'h0, run = 1'h1, ovf_seen = 1'h0;
  wire logic lclk, far_d, pin, po, poe, bclk, bv, b, ovf;
  role_e role;
  logic exp_q[$];
  int n_errors = 0;
  int num_checks = 0;
  int lneg = 0;
  assign pin = poe ? po : far_d;
  initial forever #5 clk_sys = ~clk_sys;
  far_end_model i_far_end_model (.run_i(run), .byte_clk_i(bclk), .link_clk_o(lclk), .data_o(far_d));
  ch2_tx_bit5_pin_mux i_ch2_tx_bit5_pin_mux (.clk_sys_i(clk_sys), .rst_b_i(rst_b),
    .ch2_add_bus_clock_i(lclk), .add_bus_enable_i(en), .op_mode_i(op), .frame_boundary_i(fb),
    .pin_i(pin), .pin_o(po), .pin_oe_o(poe), .ch2_tx_packet_byte_clock_o(bclk),
    .bit_valid_o(bv), .bit_o(b), .bit_ready_i(rdy), .role_o(role), .overflow_o(ovf));
  // link side keeps bits only from the third falling edge after release
  always @(negedge lclk) begin
    if (rst_b) lneg++;
    if (en && lneg > 2) exp_q.push_back(pin);
  end
  // byte clock only runs in the packet role, so every rise takes a bit
  always @(posedge bclk) exp_q.push_back(pin);
  always @(posedge clk_sys) if (ovf === 1'h1) ovf_seen <= 1'h1;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic set_mode(input logic e, input logic o);
    @(posedge clk_sys);
    en <= e;
    op <= o;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic take(input int n);
    int t;
    @(posedge clk_sys);
    rdy <= 1'h1;
    for (int i = 0; i < n; i++) begin
      t = 0;
      do begin
        @(negedge clk_sys);
        t++;
      end while (bv !== 1'h1 && t < 300);
      chk("bit_valid_o", 8'h1, 8'(bv));
      chk("bit_o", 8'(exp_q.pop_front()), 8'(b));
    end
  endtask
  task automatic pulses(input int n, input logic [7:0] e);
    logic [7:0] c;
    c = 8'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      fb <= (i < n);
      @(negedge clk_sys);
      c = c + 8'(po === 1'h1);
    end
    chk("pin_o high cycles", e, c);
  endtask
  task automatic t_frame;
    set_mode(1'h0, 1'h1);
    chk("role_o", 8'(ROLE_FRAME), 8'(role));
    chk("pin_oe_o", 8'h1, 8'(poe));
    pulses(2, 8'h2);
    set_mode(1'h0, 1'h0);
    pulses(1, 8'h0);
  endtask
  task automatic t_packet;
    chk("role_o", 8'(ROLE_PACKET), 8'(role));
    repeat (150) @(posedge clk_sys);
    take(8);
    @(posedge clk_sys);
    rdy <= 1'h0;
    set_mode(1'h1, 1'h0);
    chk("role_o", 8'(ROLE_ADD_BUS), 8'(role));
    repeat (20) @(posedge clk_sys);
    take(exp_q.size());
  endtask
  task automatic t_addbus;
    @(posedge clk_sys);
    run <= 1'h1;
    take(12);
    @(posedge clk_sys);
    run <= 1'h0;
    rdy <= 1'h0;
    repeat (20) @(posedge clk_sys);
    take(exp_q.size());
  endtask
  task automatic t_overflow;
    @(posedge clk_sys);
    rdy <= 1'h0;
    run <= 1'h1;
    repeat (10) @(negedge lclk);
    @(posedge clk_sys);
    run <= 1'h0;
    repeat (20) @(posedge clk_sys);
    chk("overflow_o", 8'h1, 8'(ovf_seen));
    take(5);
    exp_q.delete();
    repeat (5) @(negedge clk_sys);
    chk("bit_valid_o", 8'h0, 8'(bv));
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'h1;
    run <= 1'h0;
    repeat (4) @(posedge clk_sys);
    t_frame;
    t_packet;
    t_addbus;
    t_overflow;
    report_and_stop;
  end
  initial begin
    #100us;
    n_errors++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
